// *** core/pcfs_top.v ***
// pin function selector for upper port c, port d and port e
// assumes a classic wishbone master on clk_sys and a pad ring that
// routes each pin by the function and index codes driven here
`timescale 1ns/1ps
`default_nettype none
`include "pcfs_defs.vh"

module pcfs_top #(
  parameter VARIANT = 3 // 0..3 selects family variant a..d
) (
  input wire clk_sys,
  input wire reset_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire [47:0] pinFunc,
  output wire [95:0] pinIndex
);

  // variant flags, fixed at build time
  localparam VA = (VARIANT == 0);
  localparam VB = (VARIANT == 1);
  localparam VCD = (VARIANT >= 2);
  localparam [1:0] VARIANT_CODE = VARIANT[1:0];

  // selection registers
  reg [7:0] pcHigh_r; // pc7..pc4 fields, pc7/pc6 only stored
  reg [7:0] pdLow_r; // pd3..pd0 fields
  reg [7:0] pdHigh_r; // pd6..pd4 fields, top two bits absent
  reg [7:0] peLow_r; // pe3..pe0 fields
  reg [7:0] peHigh_r; // pe7..pe4 fields, pe4 only stored

  // bus handshake terms
  wire busReq; // a new request this cycle
  wire busWr; // write to the low byte lane
  reg [31:0] rdData_nxt; // read mux result

  // one request per ack; the ack cycle itself is not a new request
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // only lane 0 carries the 8-bit registers; other lanes ignored
  assign busWr = busReq & wb_we_i & wb_sel_i[0];

  // register writes; unmapped offsets take no effect
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pcHigh_r <= `PCFS_RST_PC_HIGH;
      pdLow_r <= `PCFS_RST_PD_LOW;
      pdHigh_r <= `PCFS_RST_PD_HIGH;
      peLow_r <= `PCFS_RST_PE_LOW;
      peHigh_r <= `PCFS_RST_PE_HIGH;
    end else if (busWr) begin
      if (wb_adr_i == `PCFS_OFS_PC_HIGH) begin
        // stored on every variant, even where it routes nothing
        pcHigh_r <= wb_dat_i[7:0];
      end else if (wb_adr_i == `PCFS_OFS_PD_LOW) begin
        pdLow_r <= wb_dat_i[7:0];
      end else if (wb_adr_i == `PCFS_OFS_PD_HIGH) begin
        // unimplemented top bits never take a write
        pdHigh_r <= wb_dat_i[7:0] & `PCFS_PD_HIGH_MASK;
      end else if (wb_adr_i == `PCFS_OFS_PE_LOW) begin
        peLow_r <= wb_dat_i[7:0];
      end else if (wb_adr_i == `PCFS_OFS_PE_HIGH) begin
        peHigh_r <= wb_dat_i[7:0];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    rdData_nxt = 32'h0000_0000;
    if (wb_adr_i == `PCFS_OFS_PC_HIGH) begin
      rdData_nxt[7:0] = pcHigh_r;
    end else if (wb_adr_i == `PCFS_OFS_PD_LOW) begin
      rdData_nxt[7:0] = pdLow_r;
    end else if (wb_adr_i == `PCFS_OFS_PD_HIGH) begin
      // masked again so bits 7:6 can never read back set
      rdData_nxt[7:0] = pdHigh_r & `PCFS_PD_HIGH_MASK;
    end else if (wb_adr_i == `PCFS_OFS_PE_LOW) begin
      rdData_nxt[7:0] = peLow_r;
    end else if (wb_adr_i == `PCFS_OFS_PE_HIGH) begin
      rdData_nxt[7:0] = peHigh_r;
    end else if (wb_adr_i == `PCFS_OFS_VARIANT) begin
      // lets software learn which map is built in
      rdData_nxt[1:0] = VARIANT_CODE;
    end
  end

  // ack and read data, one cycle after the request
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq;
      if (busReq & ~wb_we_i) begin
        wb_dat_o <= rdData_nxt;
      end
    end
  end

  // port c bit 4, dead on variant a
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0), .F1(`PCFS_FN_GPIO), .I1(6'd0),
    .F2(VA ? `PCFS_FN_GPIO : `PCFS_FN_TOUCH), .I2(VA ? 6'd0 : 6'd9),
    .F3(VCD ? `PCFS_FN_LCD : `PCFS_FN_GPIO), .I3(VCD ? 6'd4 : 6'd0)
  ) uPc4 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(pcHigh_r[`PCFS_FLD0]),
    .pinFunc_r(pinFunc[2:0]), .pinIndex_r(pinIndex[5:0])
  );

  // port c bit 5, dead on variant a
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0), .F1(`PCFS_FN_GPIO), .I1(6'd0),
    .F2(VA ? `PCFS_FN_GPIO : `PCFS_FN_TOUCH), .I2(VA ? 6'd0 : 6'd10),
    .F3(VCD ? `PCFS_FN_LCD : `PCFS_FN_GPIO), .I3(VCD ? 6'd5 : 6'd0)
  ) uPc5 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(pcHigh_r[`PCFS_FLD1]),
    .pinFunc_r(pinFunc[5:3]), .pinIndex_r(pinIndex[11:6])
  );

  // port d bit 0, dead on variant a
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0), .F1(`PCFS_FN_GPIO), .I1(6'd0),
    .F2(VA ? `PCFS_FN_GPIO : `PCFS_FN_TOUCH), .I2(VA ? 6'd0 : 6'd13),
    .F3(VA ? `PCFS_FN_GPIO : `PCFS_FN_LCD), .I3(VCD ? 6'd8 : 6'd0)
  ) uPd0 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(pdLow_r[`PCFS_FLD0]),
    .pinFunc_r(pinFunc[8:6]), .pinIndex_r(pinIndex[17:12])
  );

  // port d bit 1, dead on variant a
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0), .F1(`PCFS_FN_GPIO), .I1(6'd0),
    .F2(VA ? `PCFS_FN_GPIO : `PCFS_FN_TOUCH), .I2(VA ? 6'd0 : 6'd14),
    .F3(VA ? `PCFS_FN_GPIO : `PCFS_FN_LCD), .I3(VCD ? 6'd9 : (VB ? 6'd1 : 6'd0))
  ) uPd1 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(pdLow_r[`PCFS_FLD1]),
    .pinFunc_r(pinFunc[11:9]), .pinIndex_r(pinIndex[23:18])
  );

  // port d bit 2, dead on variant a
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0), .F1(`PCFS_FN_GPIO), .I1(6'd0),
    .F2(VA ? `PCFS_FN_GPIO : `PCFS_FN_TOUCH), .I2(VA ? 6'd0 : 6'd15),
    .F3(VA ? `PCFS_FN_GPIO : `PCFS_FN_LCD), .I3(VCD ? 6'd10 : (VB ? 6'd2 : 6'd0))
  ) uPd2 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(pdLow_r[`PCFS_FLD2]),
    .pinFunc_r(pinFunc[14:12]), .pinIndex_r(pinIndex[29:24])
  );

  // port d bit 3, dead on variant a
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0), .F1(`PCFS_FN_GPIO), .I1(6'd0),
    .F2(VA ? `PCFS_FN_GPIO : `PCFS_FN_TOUCH), .I2(VA ? 6'd0 : 6'd16),
    .F3(VA ? `PCFS_FN_GPIO : `PCFS_FN_LCD), .I3(VCD ? 6'd11 : (VB ? 6'd3 : 6'd0))
  ) uPd3 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(pdLow_r[`PCFS_FLD3]),
    .pinFunc_r(pinFunc[17:15]), .pinIndex_r(pinIndex[35:30])
  );

  // port d bit 4
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0), .F1(`PCFS_FN_GPIO), .I1(6'd0),
    .F2(`PCFS_FN_TOUCH), .I2(VA ? 6'd9 : 6'd17),
    .F3(`PCFS_FN_LCD), .I3(VCD ? 6'd12 : 6'd4)
  ) uPd4 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(pdHigh_r[`PCFS_FLD0]),
    .pinFunc_r(pinFunc[20:18]), .pinIndex_r(pinIndex[41:36])
  );

  // port d bit 5
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0), .F1(`PCFS_FN_GPIO), .I1(6'd0),
    .F2(`PCFS_FN_TOUCH), .I2(VA ? 6'd10 : 6'd18),
    .F3(`PCFS_FN_LCD), .I3(VCD ? 6'd13 : 6'd5)
  ) uPd5 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(pdHigh_r[`PCFS_FLD1]),
    .pinFunc_r(pinFunc[23:21]), .pinIndex_r(pinIndex[47:42])
  );

  // port d bit 6
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0), .F1(`PCFS_FN_GPIO), .I1(6'd0),
    .F2(`PCFS_FN_TOUCH), .I2(VA ? 6'd11 : 6'd19),
    .F3(`PCFS_FN_LCD), .I3(VCD ? 6'd14 : 6'd6)
  ) uPd6 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(pdHigh_r[`PCFS_FLD2]),
    .pinFunc_r(pinFunc[26:24]), .pinIndex_r(pinIndex[53:48])
  );

  // port e bit 0, plain gpio on code 10 for a and b
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0), .F1(`PCFS_FN_GPIO), .I1(6'd0),
    .F2(VCD ? `PCFS_FN_TOUCH : `PCFS_FN_GPIO), .I2(VCD ? 6'd21 : 6'd0),
    .F3(`PCFS_FN_LCD), .I3(VA ? 6'd12 : (VB ? 6'd8 : 6'd16))
  ) uPe0 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(peLow_r[`PCFS_FLD0]),
    .pinFunc_r(pinFunc[29:27]), .pinIndex_r(pinIndex[59:54])
  );

  // port e bit 1, crystal pin one on a and b
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0), .F1(`PCFS_FN_GPIO), .I1(6'd0),
    .F2(VCD ? `PCFS_FN_TOUCH : `PCFS_FN_XTAL), .I2(VCD ? 6'd22 : 6'd1),
    .F3(`PCFS_FN_LCD), .I3(VA ? 6'd13 : (VB ? 6'd9 : 6'd17))
  ) uPe1 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(peLow_r[`PCFS_FLD1]),
    .pinFunc_r(pinFunc[32:30]), .pinIndex_r(pinIndex[65:60])
  );

  // port e bit 2, capture input or timer out; crystal two on a/b
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO_TIN), .I0(`PCFS_TMR_STD),
    .F1(`PCFS_FN_TOUT), .I1(`PCFS_TMR_STD),
    .F2(VCD ? `PCFS_FN_TOUCH : `PCFS_FN_XTAL), .I2(VCD ? 6'd23 : 6'd2),
    .F3(`PCFS_FN_LCD), .I3(VA ? 6'd14 : (VB ? 6'd10 : 6'd18))
  ) uPe2 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(peLow_r[`PCFS_FLD2]),
    .pinFunc_r(pinFunc[35:33]), .pinIndex_r(pinIndex[71:66])
  );

  // port e bit 3, capture input or inverted timer out
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO_TIN), .I0(`PCFS_TMR_STD),
    .F1(`PCFS_FN_TOUT_INV), .I1(`PCFS_TMR_STD),
    .F2(VCD ? `PCFS_FN_TOUCH : `PCFS_FN_GPIO_TIN), .I2(VCD ? 6'd24 : `PCFS_TMR_STD),
    .F3(`PCFS_FN_LCD), .I3(VA ? 6'd15 : (VB ? 6'd11 : 6'd19))
  ) uPe3 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(peLow_r[`PCFS_FLD3]),
    .pinFunc_r(pinFunc[38:36]), .pinIndex_r(pinIndex[77:72])
  );

  // port e bit 5, compact timer clock input shares the gpio
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO_TIN), .I0(`PCFS_TMR_CT1),
    .F1(`PCFS_FN_GPIO_TIN), .I1(`PCFS_TMR_CT1),
    .F2(VB ? `PCFS_FN_GPIO_TIN : `PCFS_FN_TOUCH),
    .I2(VA ? 6'd14 : (VB ? `PCFS_TMR_CT1 : 6'd26)),
    .F3(`PCFS_FN_LCD), .I3(VA ? 6'd9 : (VB ? 6'd13 : 6'd21))
  ) uPe5 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(peHigh_r[`PCFS_FLD1]),
    .pinFunc_r(pinFunc[41:39]), .pinIndex_r(pinIndex[83:78])
  );

  // port e bit 6, compact timer output
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0),
    .F1(`PCFS_FN_TOUT), .I1(`PCFS_TMR_CT1),
    .F2(VB ? `PCFS_FN_GPIO : `PCFS_FN_TOUCH), .I2(VA ? 6'd15 : (VB ? 6'd0 : 6'd27)),
    .F3(`PCFS_FN_LCD), .I3(VA ? 6'd10 : (VB ? 6'd14 : 6'd22))
  ) uPe6 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(peHigh_r[`PCFS_FLD2]),
    .pinFunc_r(pinFunc[44:42]), .pinIndex_r(pinIndex[89:84])
  );

  // port e bit 7, compact timer inverted output
  pcfs_pin_decode #(
    .F0(`PCFS_FN_GPIO), .I0(6'd0),
    .F1(`PCFS_FN_TOUT_INV), .I1(`PCFS_TMR_CT1),
    .F2(VB ? `PCFS_FN_GPIO : `PCFS_FN_TOUCH), .I2(VA ? 6'd16 : (VB ? 6'd0 : 6'd28)),
    .F3(`PCFS_FN_LCD), .I3(VA ? 6'd11 : (VB ? 6'd15 : 6'd23))
  ) uPe7 (
    .clk_sys(clk_sys), .reset_n(reset_n), .sel(peHigh_r[`PCFS_FLD3]),
    .pinFunc_r(pinFunc[47:45]), .pinIndex_r(pinIndex[95:90])
  );

endmodule
`default_nettype wire

// *** inc/pcfs_defs.vh ***
// constants of the port c/d/e pin function selector
// assumes a 32-bit classic wishbone bus with byte addresses
`ifndef PCFS_DEFS_VH
`define PCFS_DEFS_VH

// register byte offsets, one aligned word each
`define PCFS_OFS_PC_HIGH 8'h00
`define PCFS_OFS_PD_LOW 8'h04
`define PCFS_OFS_PD_HIGH 8'h08
`define PCFS_OFS_PE_LOW 8'h0c
`define PCFS_OFS_PE_HIGH 8'h10
`define PCFS_OFS_VARIANT 8'h14

// reset values of the selection registers
`define PCFS_RST_PC_HIGH 8'h00
`define PCFS_RST_PD_LOW 8'h00
`define PCFS_RST_PD_HIGH 8'h00
`define PCFS_RST_PE_LOW 8'h00
`define PCFS_RST_PE_HIGH 8'h00

// implemented bits of the upper port d register
`define PCFS_PD_HIGH_MASK 8'h3f

// field positions: pin n of a register sits at bits 2n+1:2n
`define PCFS_FLD0 1:0
`define PCFS_FLD1 3:2
`define PCFS_FLD2 5:4
`define PCFS_FLD3 7:6

// routed function codes
`define PCFS_FN_GPIO 3'h0
`define PCFS_FN_GPIO_TIN 3'h1
`define PCFS_FN_TOUCH 3'h2
`define PCFS_FN_LCD 3'h3
`define PCFS_FN_TOUT 3'h4
`define PCFS_FN_TOUT_INV 3'h5
`define PCFS_FN_XTAL 3'h6

// index meaning for timer functions
`define PCFS_TMR_STD 6'h00
`define PCFS_TMR_CT1 6'h01

// widths
`define PCFS_FN_W 3
`define PCFS_IX_W 6
`define PCFS_PINS 16

`endif

// *** core/pcfs_pin_decode.v ***
// one pin's selection field decoder, with a registered result
// assumes the four code meanings are fixed at build time by the parent
`timescale 1ns/1ps
`default_nettype none
`include "pcfs_defs.vh"

module pcfs_pin_decode #(
  parameter [2:0] F0 = 3'h0, // function for code 00
  parameter [5:0] I0 = 6'h00,
  parameter [2:0] F1 = 3'h0, // function for code 01
  parameter [5:0] I1 = 6'h00,
  parameter [2:0] F2 = 3'h0, // function for code 10
  parameter [5:0] I2 = 6'h00,
  parameter [2:0] F3 = 3'h0, // function for code 11
  parameter [5:0] I3 = 6'h00
) (
  input wire clk_sys,
  input wire reset_n,
  input wire [1:0] sel,
  output reg [2:0] pinFunc_r,
  output reg [5:0] pinIndex_r
);

  reg [2:0] pinFunc_nxt; // decoded function
  reg [5:0] pinIndex_nxt; // decoded line number

  // code to function table
  always @* begin
    case (sel)
      2'b00: begin
        pinFunc_nxt = F0;
        pinIndex_nxt = I0;
      end
      2'b01: begin
        pinFunc_nxt = F1;
        pinIndex_nxt = I1;
      end
      2'b10: begin
        pinFunc_nxt = F2;
        pinIndex_nxt = I2;
      end
      default: begin
        pinFunc_nxt = F3;
        pinIndex_nxt = I3;
      end
    endcase
  end

  // registered so the pad mux never sees a decode glitch
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      // reset shows the code 00 meaning, so the pin does not move when reset ends
      pinFunc_r <= F0;
      pinIndex_r <= I0;
    end else begin
      pinFunc_r <= pinFunc_nxt;
      pinIndex_r <= pinIndex_nxt;
    end
  end

endmodule
`default_nettype wire

// *** dv/pcfs_checker.sv ***
// assertions on the bus answers and pin outputs of the pin selector
// assumes it is bound into pcfs_top, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "pcfs_defs.vh"
module pcfs_checker #(
  parameter VARIANT = 3
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [47:0] pinFunc,
  input wire logic [95:0] pinIndex
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // a request the slave has not yet answered
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // a read at one address and its answer
  sequence rd_s(logic [7:0] a);
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == a ##1 wb_ack_o;
  endsequence
  ack_follows_a: assert property (req_s |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  pd_top_zero_a:
    assert property (rd_s(`PCFS_OFS_PD_HIGH) |-> wb_dat_o[7:6] == 2'h0)
    else $error("unimplemented port d bits read nonzero");
  variant_code_a:
    assert property (rd_s(`PCFS_OFS_VARIANT) |-> wb_dat_o == VARIANT)
    else $error("variant code read wrong");
  unmapped_zero_a: assert property (rd_s(8'h18) |-> wb_dat_o == 32'h0)
    else $error("unmapped read nonzero");
  // pins move only one edge after a taken write
  pins_quiet_a:
    assert property (!$stable({pinFunc, pinIndex}) |-> $past(wb_ack_o && wb_we_i))
    else $error("pin routing changed without write");
  pc_no_lcd_a:
    assert property (VARIANT < 2 |-> pinFunc[2:0] != `PCFS_FN_LCD
      && pinFunc[5:3] != `PCFS_FN_LCD)
    else $error("port c drives lcd on small variant");
endmodule
bind pcfs_top pcfs_checker #(.VARIANT(VARIANT)) chk_u (.clk_sys, .reset_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pinFunc,
  .pinIndex);
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the pin selector, built as variant b
// assumes classic wishbone timing and registered pin outputs
`timescale 1ns/1ps
`default_nettype none
`include "pcfs_defs.vh"
module testbench;
  localparam VAR = 1; // variant b has the most irregular map
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire [47:0] pinFunc;
  wire [95:0] pinIndex;
  logic [7:0] regs [5]; // register model
  logic [31:0] rdQ [$]; // expected read data, oldest first
  logic [31:0] lfsrR = 32'h6f512962;
  int errCount = 0;
  int checks = 0;
  pcfs_top #(.VARIANT(VAR)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pinFunc(pinFunc), .pinIndex(pinIndex));
  // 40 mhz clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input [31:0] seen, input [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic [31:0] lfsr(input [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // read value the register map should give
  function automatic [31:0] exp_rd(input [7:0] a);
    if (a == `PCFS_OFS_VARIANT) return VAR;
    if (a > 8'h10 || a[1:0] != 2'h0) return 32'h0;
    return {24'h0, regs[a >> 2] & (a == `PCFS_OFS_PD_HIGH ? 8'h3f : 8'hff)};
  endfunction
  // selection code of pin slot s in the model
  function automatic [1:0] code_of(input int s);
    int r;
    int f;
    r = s < 2 ? 0 : s < 6 ? 1 : s < 9 ? 2 : s < 13 ? 3 : 4;
    f = s < 2 ? s : s < 6 ? s - 2 : s < 9 ? s - 6 : s < 13 ? s - 9 : s - 12;
    return 2'(regs[r] >> (2 * f));
  endfunction
  // expected {function, index} of slot s for code c on variant b
  function automatic [8:0] ex(input int s, input [1:0] c);
    logic [2:0] f;
    logic [5:0] i;
    f = `PCFS_FN_GPIO;
    i = 6'h00;
    if (c == 2'h3 && s > 1) begin
      f = `PCFS_FN_LCD;
      i = 6'(s < 9 ? s - 2 : s < 13 ? s - 1 : s);
    end else if (s < 9 && c == 2'h2) begin
      f = `PCFS_FN_TOUCH;
      i = 6'(s < 2 ? s + 9 : s + 11);
    end else if (s > 10) begin
      // timer slots; pe6 and pe7 fall back to plain gpio
      i = s > 12 ? `PCFS_TMR_CT1 : `PCFS_TMR_STD;
      if (c == 2'h1) f = (s == 11 || s == 14) ? `PCFS_FN_TOUT
        : s == 13 ? `PCFS_FN_GPIO_TIN : `PCFS_FN_TOUT_INV;
      else if (s < 14) f = `PCFS_FN_GPIO_TIN;
      else i = 6'h00;
    end
    if (c == 2'h2 && (s == 10 || s == 11)) begin
      f = `PCFS_FN_XTAL;
      i = 6'(s - 9);
    end
    return {f, i};
  endfunction
  // one classic cycle; a read notes its expected data first
  task automatic bus(input w, input [7:0] a, input [7:0] d, input [3:0] s);
    int n;
    if (!w) rdQ.push_back(exp_rd(a));
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!wb_ack_o && n < 20);
    if (!wb_ack_o) begin
      errCount++;
      summarize();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (w && s[0] && a <= 8'h10 && a[1:0] == 2'h0) regs[a >> 2] = d;
  endtask
  // compare all sixteen pin slots once the decoders have settled
  task automatic pins;
    logic [8:0] got;
    logic [8:0] e;
    repeat (2) @(posedge clk_sys);
    for (int s = 0; s < 16; s++) begin
      got = {pinFunc[3*s +: 3], pinIndex[6*s +: 6]};
      e = ex(s, code_of(s));
      if (s < 6) chk(got, e);
      else if (s < 9) chk(got, e);
      else if (s < 13) chk(got, e);
      else chk(got, e);
    end
  endtask
  // read answers compared in arrival order
  always @(posedge clk_sys) begin
    if (wb_ack_o && !wb_we_i && rdQ.size() > 0) chk(wb_dat_o, rdQ.pop_front());
  end
  initial begin
    for (int k = 0; k < 5; k++) regs[k] = 8'h00;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int a = 0; a <= 24; a += 4) bus(0, 8'(a), 8'h00, 4'hf);
    pins();
    $display("test reset done");
    // every code on every field at once, read back too
    for (int c = 0; c < 4; c++) begin
      for (int a = 0; a < 20; a += 4) bus(1, 8'(a), {4{2'(c)}}, 4'h1);
      for (int a = 0; a < 20; a += 4) bus(0, 8'(a), 8'h00, 4'h0);
      pins();
    end
    $display("test codes done");
    // unmapped, read-only and lane-off writes must change nothing
    bus(1, 8'h18, 8'hff, 4'hf);
    bus(1, `PCFS_OFS_VARIANT, 8'hff, 4'hf);
    bus(1, `PCFS_OFS_PC_HIGH, 8'h5a, 4'he);
    for (int a = 0; a <= 24; a += 4) bus(0, 8'(a), 8'h00, 4'hf);
    pins();
    $display("test refusals done");
    repeat (24) begin
      lfsrR = lfsr(lfsrR);
      bus(1, 8'(4 * (lfsrR[15:8] % 5)), lfsrR[7:0], 4'h1);
      bus(0, 8'(4 * (lfsrR[15:8] % 5)), 8'h00, 4'h0);
      pins();
    end
    $display("test random done");
    summarize();
  end
endmodule
`default_nettype wire
